// *** rtl/mq_pkg.sv ***
package mq_pkg;
  // Address layout
  localparam int QIDX_W = 3;
  localparam int NUM_QUEUES = 8;
  localparam int ID_W = 3;
  localparam int WADDR_W = 6;
  localparam int RADDR_W = 7;
  localparam int RADDR_NULL_BIT = 3;
  localparam int RADDR_ID_LSB = 4;
  localparam int WADDR_ID_LSB = 3;
  // Data widths
  localparam int BYTE_W = 9;
  localparam int WORD_W = 18;
  // Width select codes
  localparam logic [1:0] WIDTH_18_18 = 2'h0;
  localparam logic [1:0] WIDTH_18_9 = 2'h1;
  localparam logic [1:0] WIDTH_9_18 = 2'h2;
  localparam logic [1:0] WIDTH_9_9 = 2'h3;
  // Queue depth in bytes per queue
  localparam int QDEPTH_BYTES = 16;
  // Minimum cycles between queue selections
  localparam int SEL_SPACING = 2;
  // Controller command port states
  typedef enum logic [2:0] {
    CTL_IDLE = 3'h1,
    CTL_SEL = 3'h2,
    CTL_HOLD = 3'h4
  } ctl_state_e;
endpackage

// *** rtl/mq_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mq_link_if;
  import mq_pkg::*;
  logic [WADDR_W-1:0] write_queue_address;
  logic write_address_strobe;
  logic write_enable_n;
  logic [WORD_W-1:0] data_in;
  logic [RADDR_W-1:0] read_queue_address;
  logic read_address_strobe;
  logic read_enable_n;
  logic [WORD_W-1:0] data_out;
  logic output_valid_n;
  logic queue_full_n;
  logic queue_full_oe;
  logic [1:0] width_setup;
  logic master_reset;
  modport device (
    input write_queue_address, write_address_strobe, write_enable_n, data_in,
    input read_queue_address, read_address_strobe, read_enable_n,
    input width_setup, master_reset,
    output data_out, output_valid_n, queue_full_n, queue_full_oe
  );
  modport ctrl (
    output write_queue_address, write_address_strobe, write_enable_n, data_in,
    output read_queue_address, read_address_strobe, read_enable_n,
    output width_setup, master_reset,
    input data_out, output_valid_n, queue_full_n, queue_full_oe
  );
endinterface
`default_nettype wire

// *** rtl/mq_device.sv ***
// How it works
// RL1 - Read address bit 3 picks null queue
// RL2 - Null queue empty; output kept, valid drops
// RL3 - Pipeline words still reach output after switch
// RL4 - Controller may park on null queue
// RL5 - Write port ignores null selection
// RL6 - One word per read cycle always
// RL7 - Last word falls through at empty
// RL8 - Widths sampled at master reset
// RL9 - Bytes packed little-endian
// RL10 - Full counts write-width units
// RL11 - Valid counts read-width units
// RL12 - One width for all queues
// RL13 - Full tracked per queue, selected shown
// RL14 - Full shows new queue next edge
// RL15 - Writes start second edge after select
// RL16 - Full changes on clock edge only
// RL17 - Reads update unselected queue full status
// RL18 - Full driven only when ID matches
// RL19 - System writes one device at once
// RL20 - Selection on strobe, two cycles apart
// RL21 - Full new queue blocks writes
// RL22 - Read address: queue, null, ID
// RL23 - New queue data after two cycles
// RL24 - Reset leaves all queues empty
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mq_device
  import mq_pkg::*;
#(
  parameter int DEPTH = QDEPTH_BYTES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [ID_W-1:0] device_id_in,
  mq_link_if.device link
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // Byte storage per queue; a queue holds DEPTH bytes
  logic [BYTE_W-1:0] mem_r [NUM_QUEUES][DEPTH];
  logic [PW-1:0] wptr_r [NUM_QUEUES];
  logic [PW-1:0] rptr_r [NUM_QUEUES];
  logic [CW-1:0] cnt_r [NUM_QUEUES];
  logic in9_r, out9_r;
  logic [QIDX_W-1:0] wq_new_r, wq_r;
  logic wsel_new_r, wsel_r, wmatch_r;
  logic [QIDX_W-1:0] rq_r;
  logic rnull_r, rmine_r;
  logic st1_v_r;
  logic [WORD_W-1:0] st1_d_r, dout_r;
  logic ov_n_r, ff_n_r, ff_oe_r;

  function automatic logic [CW-1:0] units(input logic wide);
    units = wide ? CW'(2) : CW'(1);
  endfunction

  // Pointer step wraps inside the queue's own storage
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr, input logic [CW-1:0] inc);
    bump = PW'(ptr + inc);
  endfunction

  // Widths latched only at master reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      in9_r <= 1'b0;
      out9_r <= 1'b0;
    end else if (clk_en_in && link.master_reset) begin
      // Widths are global: one pair serves every queue
      in9_r <= link.width_setup[1]; // see RL8 see RL12
      out9_r <= link.width_setup[0];
    end
  end

  // Write selection: address captured, becomes active one edge later
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wq_new_r <= '0;
      wq_r <= '0;
      wsel_new_r <= 1'b0;
      wsel_r <= 1'b0;
      wmatch_r <= 1'b0;
    end else if (clk_en_in) begin
      wsel_new_r <= 1'b0;
      if (link.write_address_strobe) begin // see RL20
        wq_new_r <= link.write_queue_address[QIDX_W-1:0]; // see RL5
        wmatch_r <= link.write_queue_address[WADDR_ID_LSB +: ID_W] == device_id_in;
        wsel_new_r <= 1'b1;
      end
      // Writes stay on the old queue through the select edge and the next
      if (wsel_new_r) begin
        wq_r <= wq_new_r; // see RL15
        wsel_r <= wmatch_r;
      end
    end
  end

  // Effective write and read strobes this cycle
  logic wr_go, rd_go;
  logic [WORD_W-1:0] rd_word;
  logic rd_avail;
  always_comb begin
    // Room counts write-port units, data on hand read-port units
    wr_go = wsel_r && !link.write_enable_n && !link.master_reset
      && (DEPTH - cnt_r[wq_r] >= units(!in9_r)); // see RL21 see RL10
    rd_avail = rmine_r && !rnull_r
      && (cnt_r[rq_r] >= units(!out9_r)); // see RL11 see RL1
    // Wide read takes the older byte as the low half
    rd_word = {mem_r[rq_r][bump(rptr_r[rq_r], CW'(1))], mem_r[rq_r][rptr_r[rq_r]]};
    if (out9_r) begin
      rd_word = {BYTE_W'(0), mem_r[rq_r][rptr_r[rq_r]]};
    end
    // Fall-through: stage refills whenever it is empty or being drained
    rd_go = rd_avail && (!st1_v_r || !link.read_enable_n || ov_n_r); // see RL6 see RL7
  end

  // Queue pointers and occupancy; both ports touch any queue
  always_ff @(posedge core_clk_in) begin
    if (rst_in || (clk_en_in && link.master_reset)) begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        wptr_r[q] <= '0; // see RL24
        rptr_r[q] <= '0;
        cnt_r[q] <= '0;
      end
    end else if (clk_en_in) begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        cnt_r[q] <= CW'(cnt_r[q]
          + ((wr_go && wq_r == QIDX_W'(q)) ? units(!in9_r) : CW'(0))
          - ((rd_go && rq_r == QIDX_W'(q)) ? units(!out9_r) : CW'(0))); // see RL17 see RL13
      end
      // Low byte first, so a wide word lands little-endian
      if (wr_go) begin
        mem_r[wq_r][wptr_r[wq_r]] <= link.data_in[BYTE_W-1:0]; // see RL9
        if (!in9_r) begin
          mem_r[wq_r][bump(wptr_r[wq_r], CW'(1))] <= link.data_in[WORD_W-1:BYTE_W];
        end
        wptr_r[wq_r] <= bump(wptr_r[wq_r], units(!in9_r));
      end
      // Any queue may be read, even one idle on the write port
      if (rd_go) begin
        rptr_r[rq_r] <= bump(rptr_r[rq_r], units(!out9_r));
      end
    end
  end

  // Full flag: selected queue only, driven while ID matches
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ff_n_r <= 1'b1;
      ff_oe_r <= 1'b0;
    end else if (clk_en_in) begin
      // Registered so every change lands on a rising edge
      ff_n_r <= !(DEPTH - cnt_r[wsel_new_r ? wq_new_r : wq_r] < units(!in9_r)); // see RL14 see RL16
      // Line released one edge after the select edge that names another device
      ff_oe_r <= wsel_new_r ? wmatch_r : wsel_r; // see RL18
    end
  end

  // Read selection: new queue feeds the stage from the next edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rq_r <= '0;
      rnull_r <= 1'b1;
      rmine_r <= 1'b0;
    end else if (clk_en_in) begin
      // The select edge still reads the old queue, so no dead cycle
      if (link.read_address_strobe) begin // see RL22
        rq_r <= link.read_queue_address[QIDX_W-1:0]; // see RL23
        // Null and foreign selects both stop reads here
        rnull_r <= link.read_queue_address[RADDR_NULL_BIT]; // see RL1
        rmine_r <= link.read_queue_address[RADDR_ID_LSB +: ID_W] == device_id_in;
      end
    end
  end

  // Two-stage output pipeline; old words drain during a switch
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st1_v_r <= 1'b0;
      st1_d_r <= '0;
      dout_r <= '0;
      ov_n_r <= 1'b1;
    end else if (clk_en_in) begin
      // Empty stage leaves a stale word in place, flagged invalid
      if (!link.read_enable_n || ov_n_r) begin
        if (st1_v_r) begin
          dout_r <= st1_d_r; // see RL3
          ov_n_r <= 1'b0;
        end else begin
          ov_n_r <= 1'b1; // see RL2
        end
      end
      // Stage refills on the same edge it hands its word on
      if (rd_go) begin
        st1_d_r <= rd_word;
        st1_v_r <= 1'b1;
      end else if (!link.read_enable_n || ov_n_r) begin
        st1_v_r <= 1'b0;
      end
    end
  end

  assign link.data_out = dout_r;
  assign link.output_valid_n = ov_n_r;
  assign link.queue_full_n = ff_n_r;
  assign link.queue_full_oe = ff_oe_r;
endmodule
`default_nettype wire

// *** rtl/mq_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module mq_controller
  import mq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [1:0] width_in,
  input wire logic init_in,
  input wire logic wsel_in,
  input wire logic [WADDR_W-1:0] waddr_in,
  input wire logic wr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  input wire logic rsel_in,
  input wire logic [RADDR_W-1:0] raddr_in,
  input wire logic rd_in,
  output logic [WORD_W-1:0] rdata_out,
  output logic rvalid_out,
  output logic full_out,
  output logic wsel_busy_out,
  mq_link_if.ctrl link
);
  ctl_state_e wst_r;
  logic [WADDR_W-1:0] wa_r;
  logic was_r, wen_n_r, mr_r, rsel_ok_r;
  logic [WORD_W-1:0] din_r;
  logic [RADDR_W-1:0] ra_r;
  logic ras_r, ren_n_r;
  logic [1:0] width_r;

  // Write selection spacing: select, hold, then idle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wst_r <= CTL_IDLE;
      wa_r <= '0;
      was_r <= 1'b0;
    end else if (clk_en_in) begin
      was_r <= 1'b0;
      case (wst_r)
        CTL_IDLE: begin
          if (wsel_in) begin
            wa_r <= waddr_in; // see RL20
            was_r <= 1'b1;
            wst_r <= CTL_SEL;
          end
        end
        CTL_SEL: wst_r <= CTL_HOLD;
        CTL_HOLD: wst_r <= CTL_IDLE; // see RL19
        default: wst_r <= CTL_IDLE;
      endcase
    end
  end

  // Write data, reset and width pins, read port drive
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wen_n_r <= 1'b1;
      din_r <= '0;
      mr_r <= 1'b1;
      width_r <= WIDTH_18_18;
      ra_r <= '0;
      ras_r <= 1'b0;
      ren_n_r <= 1'b1;
      rsel_ok_r <= 1'b1;
    end else if (clk_en_in) begin
      mr_r <= init_in; // see RL8 see RL24
      width_r <= width_in;
      // Holding off during the selection gap keeps writes off the old queue
      wen_n_r <= !(wr_in && wst_r == CTL_IDLE && !was_r); // see RL15
      din_r <= wdata_in;
      // Null queue bit passed through; may park there indefinitely
      ras_r <= rsel_in && rsel_ok_r && !ras_r; // see RL4 see RL1 see RL22
      rsel_ok_r <= !(rsel_in && rsel_ok_r && !ras_r);
      if (!rsel_ok_r) begin
        rsel_ok_r <= 1'b1;
      end
      if (rsel_in) begin
        ra_r <= raddr_in;
      end
      ren_n_r <= !rd_in;
    end
  end

  // Status returned to the user side
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
      rvalid_out <= 1'b0;
      full_out <= 1'b0;
      wsel_busy_out <= 1'b0;
    end else if (clk_en_in) begin
      rdata_out <= link.data_out;
      rvalid_out <= !link.output_valid_n && !ren_n_r;
      full_out <= link.queue_full_oe && !link.queue_full_n;
      wsel_busy_out <= wst_r != CTL_IDLE || wsel_in;
    end
  end

  assign link.write_queue_address = wa_r;
  assign link.write_address_strobe = was_r;
  assign link.write_enable_n = wen_n_r;
  assign link.data_in = din_r;
  assign link.read_queue_address = ra_r;
  assign link.read_address_strobe = ras_r;
  assign link.read_enable_n = ren_n_r;
  assign link.master_reset = mr_r;
  assign link.width_setup = width_r;
endmodule
`default_nettype wire

// *** dv/mq_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module mq_link_asserts
  import mq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ID_W-1:0] device_id_in,
  input wire logic [WADDR_W-1:0] write_queue_address,
  input wire logic write_address_strobe,
  input wire logic write_enable_n,
  input wire logic [RADDR_W-1:0] read_queue_address,
  input wire logic read_address_strobe,
  input wire logic read_enable_n,
  input wire logic [WORD_W-1:0] data_out,
  input wire logic output_valid_n,
  input wire logic queue_full_n,
  input wire logic queue_full_oe,
  input wire logic master_reset
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic quiet;
  logic wid_ok;
  logic rnull;
  logic null_r;
  // Quiet cycle: no traffic; after six in a row, nothing at the outputs may move
  assign quiet = write_enable_n && read_enable_n && !write_address_strobe && !read_address_strobe && !master_reset;
  assign wid_ok = write_queue_address[WADDR_W-1:WADDR_ID_LSB] == device_id_in;
  assign rnull = read_address_strobe && read_queue_address[RADDR_NULL_BIT]
    && read_queue_address[RADDR_W-1:RADDR_ID_LSB] == device_id_in;
  // Read side parked on the null queue
  always_ff @(posedge core_clk_in) begin
    if (rst_in || master_reset) begin
      null_r <= 1'h0;
    end else if (read_address_strobe) begin
      null_r <= rnull;
    end
  end
  // Enable follows the select edge by one edge, so it is seen two edges on
  a_full_oe_match: assert property (write_address_strobe && wid_ok |-> ##2 queue_full_oe)
    else $error("full line not driven");
  a_full_oe_miss: assert property (write_address_strobe && !wid_ok |-> ##2 !queue_full_oe)
    else $error("full line driven for other id");
  // Full lags the cleared count by one edge, hence three edges of reset
  a_reset_flags: assert property (master_reset [*3] |-> queue_full_n && output_valid_n)
    else $error("flags not cleared");
  // Parked three cycles with output already invalid, the pipeline is empty and only invalid data remains
  a_null_stays: assert property (null_r && $past(null_r, 3) && output_valid_n && !read_address_strobe
    |=> output_valid_n)
    else $error("null queue gave valid data");
  a_out_hold: assert property (quiet [*6] |=> $stable(data_out) && $stable(output_valid_n))
    else $error("output moved while idle");
  a_full_hold: assert property (quiet [*6] |=> $stable(queue_full_n) && $stable(queue_full_oe))
    else $error("full moved while idle");
  a_wsel_gap: assert property (write_address_strobe |=> !write_address_strobe)
    else $error("write selects too close");
  a_rsel_gap: assert property (read_address_strobe |=> !read_address_strobe)
    else $error("read selects too close");
  c_null: cover property (rnull);
  c_full: cover property (!queue_full_n && queue_full_oe);
  c_foreign: cover property (write_address_strobe && !wid_ok);
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mq_pkg::*;
  localparam logic [ID_W-1:0] MY_ID = 3'h5; // arbitrary static id
  localparam int DEPTH = 8;
  typedef struct packed {
    logic [1:0] w;
    logic [17:0] d0;
    logic [17:0] d1;
    logic [17:0] e0;
    logic [17:0] e1;
    logic [1:0] n;
  } row_s;
  // Width code, two writes, expected reads and their count
  row_s rows [4] = '{
    '{2'h0, 18'h2A5A5, 18'h15A5A, 18'h2A5A5, 18'h15A5A, 2'h2},
    '{2'h1, 18'h3C1F0, 18'h00000, 18'h001F0, 18'h001E0, 2'h2},
    '{2'h2, 18'h000AB, 18'h00155, 18'h2AAAB, 18'h00000, 2'h1},
    '{2'h3, 18'h001C3, 18'h0003E, 18'h001C3, 18'h0003E, 2'h2}};
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [1:0] width_in = 2'h0;
  logic init_in = 1'h1;
  logic wsel_in = 1'h0;
  logic [WADDR_W-1:0] waddr_in = 6'h00;
  logic wr_in = 1'h0;
  logic [WORD_W-1:0] wdata_in = 18'h00000;
  logic rsel_in = 1'h0;
  logic [RADDR_W-1:0] raddr_in = 7'h00;
  logic rd_in = 1'h0;
  logic [WORD_W-1:0] rdata_out;
  logic rvalid_out;
  logic full_out;
  logic wsel_busy_out;
  logic [WORD_W-1:0] m;
  logic [WORD_W-1:0] got [$];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  mq_link_if link ();
  mq_device #(.DEPTH(DEPTH)) mq_device_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'h1),
    .device_id_in(MY_ID), .link(link));
  mq_controller mq_controller_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'h1),
    .width_in(width_in), .init_in(init_in), .wsel_in(wsel_in), .waddr_in(waddr_in), .wr_in(wr_in),
    .wdata_in(wdata_in), .rsel_in(rsel_in), .raddr_in(raddr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .full_out(full_out), .wsel_busy_out(wsel_busy_out), .link(link));
  mq_link_asserts mq_link_asserts_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .device_id_in(MY_ID),
    .write_queue_address(link.write_queue_address), .write_address_strobe(link.write_address_strobe),
    .write_enable_n(link.write_enable_n), .read_queue_address(link.read_queue_address),
    .read_address_strobe(link.read_address_strobe), .read_enable_n(link.read_enable_n),
    .data_out(link.data_out), .output_valid_n(link.output_valid_n), .queue_full_n(link.queue_full_n),
    .queue_full_oe(link.queue_full_oe), .master_reset(link.master_reset));
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic init(input logic [1:0] w);
    init_in <= 1'h1;
    width_in <= w;
    step(3);
    init_in <= 1'h0;
    step(3);
    @(negedge core_clk_in);
    chk("reset flags", 18'h3, {16'h0, link.queue_full_n, link.output_valid_n});
    @(posedge core_clk_in);
  endtask
  // Full line must still show the old queue one edge after the select, the new one after two
  task automatic wsel(input logic [WADDR_W-1:0] a, input logic fo, input logic fn, input logic oe);
    wsel_in <= 1'h1;
    waddr_in <= a;
    step(1);
    wsel_in <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk_in);
      if (link.write_address_strobe === 1'h1) break;
    end
    chk("select busy", 18'h1, 18'(wsel_busy_out));
    @(negedge core_clk_in);
    chk("full old", 18'(fo), 18'(link.queue_full_n));
    @(negedge core_clk_in);
    chk("full oe", 18'(oe), 18'(link.queue_full_oe));
    if (oe) chk("full new", 18'(fn), 18'(link.queue_full_n));
    step(2);
  endtask
  task automatic wrn(input int n, input logic [17:0] d0, input logic [17:0] d1);
    wr_in <= 1'h1;
    for (int i = 0; i < n; i++) begin
      wdata_in <= (i == 1) ? d1 : d0 + 18'(i);
      step(1);
    end
    wr_in <= 1'h0;
    step(2);
  endtask
  task automatic rsel(input logic [RADDR_W-1:0] a);
    rsel_in <= 1'h1;
    raddr_in <= a;
    step(1);
    rsel_in <= 1'h0;
    step(5);
  endtask
  task automatic rdn(input int n);
    got.delete();
    rd_in <= 1'h1;
    for (int i = 0; i < 30; i++) begin
      @(negedge core_clk_in);
      if (rvalid_out === 1'h1) got.push_back(rdata_out);
      if (got.size() >= n) break;
      @(posedge core_clk_in);
    end
    @(posedge core_clk_in);
    rd_in <= 1'h0;
    step(4);
  endtask
  initial begin
    step(4);
    rst_in <= 1'h0;
    foreach (rows[k]) begin
      init(rows[k].w);
      wsel({MY_ID, 3'(k)}, 1'h1, 1'h1, 1'h1);
      wrn(2, rows[k].d0, rows[k].d1);
      rsel({MY_ID, 1'h0, 3'(k)});
      rdn(int'(rows[k].n));
      m = rows[k].w[0] ? 18'h001FF : 18'h3FFFF;
      chk("count", 18'(rows[k].n), 18'(got.size()));
      chk("word0", rows[k].e0, got[0] & m);
      if (rows[k].n == 2'h2) chk("word1", rows[k].e1, got[1] & m);
    end
    // Fill a queue past its depth, then drain it while another queue holds the write port
    init(2'h0);
    wsel({MY_ID, 3'h6}, 1'h1, 1'h1, 1'h1);
    wrn(DEPTH / 2 + 2, 18'h10000, 18'h10001);
    chk("full", 18'h1, 18'(full_out));
    wsel({MY_ID, 3'h7}, 1'h0, 1'h1, 1'h1);
    rsel({MY_ID, 1'h0, 3'h6});
    rdn(DEPTH / 2 + 2);
    chk("kept", 18'(DEPTH / 2), 18'(got.size()));
    chk("last", 18'h10003, link.data_out);
    wsel({MY_ID, 3'h6}, 1'h1, 1'h1, 1'h1);
    // Park on null with two words in the pipeline and new data behind them
    wrn(2, 18'h0A0A0, 18'h0B0B0);
    rsel({MY_ID, 1'h1, 3'h6});
    wrn(1, 18'h0D0D0, 18'h00000);
    rdn(3);
    chk("drained", 18'h2, 18'(got.size()));
    chk("drain1", 18'h0B0B0, got[1]);
    chk("null ov", 18'h1, 18'(link.output_valid_n));
    chk("null out", 18'h0B0B0, link.data_out);
    rsel({MY_ID, 1'h0, 3'h6});
    rdn(1);
    chk("after null", 18'h0D0D0, got[0]);
    wsel({3'h2, 3'h1}, 1'h1, 1'h1, 1'h0);
    conclude();
  end
endmodule
`default_nettype wire
